/* File: logic/mmc_measure_ctrl.sv */
// Measurement sequencer, result registers and register file of the magnetometer.
// Assumes a serial bus engine on the link clock that issues pointer, write, read
// and stop commands, and an analog front end on the core clock.
`timescale 1ns/1ps

module mmc_measure_ctrl
  import mmc_pkg::*;
#(
  parameter int unsigned P_MEAS_CYC  = MEAS_CYC,
  parameter int unsigned P_PER1_CYC  = PER1_CYC,
  parameter int unsigned P_PER2_CYC  = PER2_CYC,
  parameter int unsigned P_PER3_CYC  = PER3_CYC,
  parameter int unsigned P_PER4_CYC  = PER4_CYC,
  parameter logic [7:0]  P_MAKER_ID  = 8'h5a,    // Arbitrary value
  parameter logic [7:0]  P_PART_ID   = 8'h3c     // Arbitrary value
) (
  // Core clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  // Link clock domain
  input  wire logic               i_lk_clk,
  input  wire logic               i_lk_cmd_valid,
  input  wire logic [1:0]         i_lk_cmd,
  input  wire logic [7:0]         i_lk_data,
  input  wire logic               i_lk_hs,
  output logic                    o_lk_cmd_ready,
  output logic [7:0]              o_lk_rdata,
  output logic                    o_lk_rvalid,
  // Analog front end
  input  wire logic signed [15:0] i_afe_x,
  input  wire logic signed [15:0] i_afe_y,
  input  wire logic signed [15:0] i_afe_z,
  output logic                    o_afe_power,
  output logic                    o_afe_selftest,
  output logic                    o_osc_run
);

  ////////////////////////////////////////////////////////////////////////////
  // State types

  typedef struct packed {
    logic [4:0]         mode;
    mmc_fsm_t           fsm;
    logic [19:0]        cnt;
    logic [7:0]         ptr;
    logic signed [15:0] res_x;
    logic signed [15:0] res_y;
    logic signed [15:0] res_z;
    logic               ready;
    logic               skip;
    logic               ovf;
    logic               rd_active;
    logic               req_s1;
    logic               req_s2;
    logic               req_s3;
    logic               ack_tgl;
    logic [7:0]         rdata;
    logic               hs_s1;
    logic               hs_s2;
  } mmc_core_t;

  typedef struct packed {
    logic       req_tgl;
    mmc_cmd_t   cmd;
    logic [7:0] data;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_s3;
    logic [7:0] rdata;
    logic       rvalid;
    logic       hs;
  } mmc_link_t;

  mmc_core_t core_ff;
  mmc_core_t nxt_core;
  mmc_link_t link_ff;
  mmc_link_t nxt_link;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Limit a raw axis sample to the documented result range
  function automatic logic signed [15:0] clamp(input logic signed [15:0] v);
    if (v > RES_MAX) begin
      clamp = RES_MAX;
    end else if (v < RES_MIN) begin
      clamp = RES_MIN;
    end else begin
      clamp = v;
    end
  endfunction

  // Magnitude of a clamped result, never above 8190
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Period of the continuous mode in force
  function automatic logic [19:0] period(input logic [4:0] m);
    case (m)
      MMC_MODE_CONT1: period = 20'(P_PER1_CYC - 1);
      MMC_MODE_CONT2: period = 20'(P_PER2_CYC - 1);
      MMC_MODE_CONT3: period = 20'(P_PER3_CYC - 1);
      default:        period = 20'(P_PER4_CYC - 1);
    endcase
  endfunction

  function automatic logic is_cont(input logic [4:0] m);
    is_cont = (m == MMC_MODE_CONT1) || (m == MMC_MODE_CONT2) ||
              (m == MMC_MODE_CONT3) || (m == MMC_MODE_CONT4);
  endfunction

  function automatic logic is_meas(input logic [4:0] m);
    is_meas = is_cont(m) || (m == MMC_MODE_SINGLE) || (m == MMC_MODE_SELF);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register read multiplexer

  logic [7:0] rd_mux;

  // Unmapped and constant-zero positions read as zero
  always_comb begin
    case (core_ff.ptr)
      ADDR_MAKER: rd_mux = P_MAKER_ID;
      ADDR_PART:  rd_mux = P_PART_ID;
      ADDR_MISC1: rd_mux = MISC_RST;
      ADDR_MISC2: rd_mux = MISC_RST;
      ADDR_STA: begin
        rd_mux                = ZERO_BYTE;
        rd_mux[STA_READY_BIT] = core_ff.ready;
        rd_mux[STA_SKIP_BIT]  = core_ff.skip;
        rd_mux[STA_HS_BIT]    = core_ff.hs_s2;
      end
      ADDR_XL:    rd_mux = core_ff.res_x[7:0];
      ADDR_XH:    rd_mux = core_ff.res_x[15:8];
      ADDR_YL:    rd_mux = core_ff.res_y[7:0];
      ADDR_YH:    rd_mux = core_ff.res_y[15:8];
      ADDR_ZL:    rd_mux = core_ff.res_z[7:0];
      ADDR_ZH:    rd_mux = core_ff.res_z[15:8];
      ADDR_TEMP:  rd_mux = TEMP_RST;
      ADDR_STB: begin
        rd_mux              = ZERO_BYTE;
        rd_mux[STB_OVF_BIT] = core_ff.ovf;
      end
      ADDR_MODE:  rd_mux = {3'h0, core_ff.mode};
      default:    rd_mux = ZERO_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain next state

  logic signed [15:0] cx;
  logic signed [15:0] cy;
  logic signed [15:0] cz;
  logic [15:0]        mag_sum;

  assign cx      = clamp(i_afe_x);
  assign cy      = clamp(i_afe_y);
  assign cz      = clamp(i_afe_z);
  assign mag_sum = mag(cx) + mag(cy) + mag(cz);

  always_comb begin
    nxt_core = core_ff;
    // Link-side request toggle through three flops, speed level through two
    nxt_core.req_s1 = link_ff.req_tgl;
    nxt_core.req_s2 = core_ff.req_s1;
    nxt_core.req_s3 = core_ff.req_s2;
    nxt_core.hs_s1  = link_ff.hs;
    nxt_core.hs_s2  = core_ff.hs_s1;

    // Register commands; flag clears come first so a same-cycle event wins
    if (core_ff.req_s2 != core_ff.req_s3) begin
      nxt_core.ack_tgl = ~core_ff.ack_tgl;
      case (link_ff.cmd)
        MMC_CMD_PTR: begin
          nxt_core.ptr = link_ff.data;
        end
        MMC_CMD_WRITE: begin
          // Only the mode byte stores; read-only offsets drop the write
          if (core_ff.ptr == ADDR_MODE) begin
            nxt_core.mode = link_ff.data[4:0];
          end
          nxt_core.ptr = core_ff.ptr + 8'h01;
        end
        MMC_CMD_READ: begin
          nxt_core.rdata = rd_mux;
          nxt_core.ptr   = core_ff.ptr + 8'h01;
          if (core_ff.ptr >= ADDR_STA && core_ff.ptr <= ADDR_STB) begin
            nxt_core.rd_active = 1'b1;
          end
          if (core_ff.ptr >= ADDR_XL && core_ff.ptr <= ADDR_STB) begin
            nxt_core.ready = 1'b0;
            nxt_core.skip  = 1'b0;
          end
          if (core_ff.ptr == ADDR_STB) begin
            nxt_core.ovf = 1'b0;
          end
        end
        default: begin
          nxt_core.rd_active = 1'b0;
        end
      endcase
    end

    // Measurement sequencer; front end runs only in the measure state
    case (core_ff.fsm)
      MMC_IDLE: begin
        if (is_meas(core_ff.mode)) begin
          nxt_core.fsm = MMC_MEAS;
          nxt_core.cnt = 20'h00000;
          nxt_core.ovf = 1'b0;
        end
      end
      MMC_MEAS: begin
        nxt_core.cnt = core_ff.cnt + 20'h00001;
        if (core_ff.mode == MMC_MODE_OFF) begin
          nxt_core.fsm = MMC_IDLE;
        end else if (core_ff.cnt == 20'(P_MEAS_CYC - 1)) begin
          if (core_ff.rd_active) begin
            nxt_core.skip = 1'b1;
          end else begin
            nxt_core.res_x = cx;
            nxt_core.res_y = cy;
            nxt_core.res_z = cz;
            nxt_core.ready = 1'b1;
            nxt_core.ovf   = (mag_sum >= OVF_SUM);
            if (nxt_core.ready && core_ff.ready) begin
              nxt_core.skip = 1'b1;
            end
          end
          if (is_cont(core_ff.mode)) begin
            nxt_core.fsm = MMC_WAIT;
          end else begin
            nxt_core.mode = MMC_MODE_OFF;
            nxt_core.fsm  = MMC_IDLE;
          end
        end
      end
      MMC_WAIT: begin
        nxt_core.cnt = core_ff.cnt + 20'h00001;
        if (core_ff.mode == MMC_MODE_OFF) begin
          nxt_core.fsm = MMC_IDLE;
        end else if (core_ff.cnt >= period(core_ff.mode)) begin
          nxt_core.fsm = MMC_MEAS;
          nxt_core.cnt = 20'h00000;
          nxt_core.ovf = 1'b0;
        end
      end
      default: begin
        nxt_core.fsm = MMC_IDLE;
      end
    endcase

    // Soft reset restores defaults but keeps the crossing and pointer intact
    if ((core_ff.req_s2 != core_ff.req_s3) && (link_ff.cmd == MMC_CMD_WRITE) &&
        (core_ff.ptr == ADDR_SOFT_RESET_BIT) && link_ff.data[SOFT_RESET_BIT_BIT]) begin
      nxt_core.mode      = MMC_MODE_OFF;
      nxt_core.fsm       = MMC_IDLE;
      nxt_core.cnt       = 20'h00000;
      nxt_core.res_x     = 16'sh0000;
      nxt_core.res_y     = 16'sh0000;
      nxt_core.res_z     = 16'sh0000;
      nxt_core.ready     = 1'b0;
      nxt_core.skip      = 1'b0;
      nxt_core.ovf       = 1'b0;
      nxt_core.rd_active = 1'b0;
    end
  end

  // Core registers; reset leaves mode at power-down
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_ff <= '0;
    end else begin
      core_ff <= nxt_core;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain next state

  // Command and data are held while busy, so the core reads them settled
  always_comb begin
    nxt_link        = link_ff;
    nxt_link.ack_s1 = core_ff.ack_tgl;
    nxt_link.ack_s2 = link_ff.ack_s1;
    nxt_link.ack_s3 = link_ff.ack_s2;
    nxt_link.hs     = i_lk_hs;
    nxt_link.rvalid = 1'b0;
    if (i_lk_cmd_valid && o_lk_cmd_ready) begin
      nxt_link.req_tgl = ~link_ff.req_tgl;
      nxt_link.cmd     = mmc_cmd_t'(i_lk_cmd);
      nxt_link.data    = i_lk_data;
    end
    if (link_ff.ack_s2 != link_ff.ack_s3) begin
      nxt_link.rdata  = core_ff.rdata;
      nxt_link.rvalid = (link_ff.cmd == MMC_CMD_READ);
    end
  end

  // Link registers; the link clock may stop between frames
  always_ff @(posedge i_lk_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link_ff <= '0;
    end else begin
      link_ff <= nxt_link;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // One command in flight at a time; ready returns after the answer is caught
  assign o_lk_cmd_ready = (link_ff.req_tgl == link_ff.ack_s3);
  assign o_lk_rdata     = link_ff.rdata;
  assign o_lk_rvalid    = link_ff.rvalid;
  assign o_afe_power    = (core_ff.fsm == MMC_MEAS);
  assign o_afe_selftest = (core_ff.fsm == MMC_MEAS) &&
                          (core_ff.mode == MMC_MODE_SELF);
  assign o_osc_run      = (core_ff.fsm != MMC_IDLE);

endmodule

/* File: logic/mmc_pkg.sv */
// Constants, types and the register map of the magnetometer measure control.
// Assumes a 10 MHz core clock and a link-side engine that forwards bus commands.
//
// Contract
// - Maker and part identity bytes fixed, read-only
// - Two misc information bytes read as zero
// - Measurement end loads results, sets ready flag
// - Result or status-b read clears ready flag
// - Unread results overwritten, overrun flag set
// - Result or status-b read clears overrun flag
// - Completion during ongoing read: keep, skip flag
// - Fast-speed flag follows bus high-speed mode
// - Axis results clamped to signed +-8190
// - X, Y, Z low byte first, consecutive
// - Axis magnitude sum at limit sets overflow
// - Overflow cleared by status-b read, next start
// - Power-down stops measuring, registers stay accessible
// - Every reset leaves the block in power-down
// - Single mode: one measurement, then power-down
// - Results stay readable until next measurement
// - Continuous modes repeat at 10/20/50/100 Hz
// - Between continuous measurements only oscillator runs
// - Self-test: energize source, measure, power-down
// - Soft reset restores defaults, bit self-clears
// - Pointer addressing, increments after each byte
package mmc_pkg;

  // Core clock and measurement timing
  localparam int unsigned CLK_MHZ      = 10;
  localparam int unsigned MEAS_TIME_US = 4000;
  localparam int unsigned MEAS_CYC     = MEAS_TIME_US * CLK_MHZ;
  localparam int unsigned PER1_US      = 1000000 / 10;
  localparam int unsigned PER2_US      = 1000000 / 20;
  localparam int unsigned PER3_US      = 1000000 / 50;
  localparam int unsigned PER4_US      = 1000000 / 100;
  localparam int unsigned PER1_CYC     = PER1_US * CLK_MHZ;
  localparam int unsigned PER2_CYC     = PER2_US * CLK_MHZ;
  localparam int unsigned PER3_CYC     = PER3_US * CLK_MHZ;
  localparam int unsigned PER4_CYC     = PER4_US * CLK_MHZ;

  // Register offsets
  localparam logic [7:0] ADDR_MAKER  = 8'h00;
  localparam logic [7:0] ADDR_PART   = 8'h01;
  localparam logic [7:0] ADDR_MISC1  = 8'h02;
  localparam logic [7:0] ADDR_MISC2  = 8'h03;
  localparam logic [7:0] ADDR_STA    = 8'h10;
  localparam logic [7:0] ADDR_XL     = 8'h11;
  localparam logic [7:0] ADDR_XH     = 8'h12;
  localparam logic [7:0] ADDR_YL     = 8'h13;
  localparam logic [7:0] ADDR_YH     = 8'h14;
  localparam logic [7:0] ADDR_ZL     = 8'h15;
  localparam logic [7:0] ADDR_ZH     = 8'h16;
  localparam logic [7:0] ADDR_TEMP   = 8'h17;
  localparam logic [7:0] ADDR_STB    = 8'h18;
  localparam logic [7:0] ADDR_MODE   = 8'h31;
  localparam logic [7:0] ADDR_SOFT_RESET_BIT   = 8'h32;

  // Field positions and fixed values
  localparam int unsigned STA_READY_BIT = 0;
  localparam int unsigned STA_SKIP_BIT  = 1;
  localparam int unsigned STA_HS_BIT    = 7;
  localparam int unsigned STB_OVF_BIT   = 3;
  localparam int unsigned SOFT_RESET_BIT_BIT      = 0;
  localparam logic [7:0]  MISC_RST      = 8'h00;
  localparam logic [7:0]  TEMP_RST      = 8'h00;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

  // Result range and overflow limit in counts
  localparam logic signed [15:0] RES_MAX  = 16'sh1ffe;
  localparam logic signed [15:0] RES_MIN  = -16'sh1ffe;
  localparam logic [15:0]        OVF_SUM  = 16'h1ffe;

  // Operating mode codes
  typedef enum logic [4:0] {
    MMC_MODE_OFF    = 5'h00,
    MMC_MODE_SINGLE = 5'h01,
    MMC_MODE_CONT1  = 5'h02,
    MMC_MODE_CONT2  = 5'h04,
    MMC_MODE_CONT3  = 5'h06,
    MMC_MODE_CONT4  = 5'h08,
    MMC_MODE_SELF   = 5'h10
  } mmc_mode_t;

  // Measurement sequencer states
  typedef enum logic [1:0] {
    MMC_IDLE = 2'b00,
    MMC_MEAS = 2'b01,
    MMC_WAIT = 2'b10
  } mmc_fsm_t;

  // Commands from the link-side bus engine
  typedef enum logic [1:0] {
    MMC_CMD_PTR   = 2'b00,
    MMC_CMD_WRITE = 2'b01,
    MMC_CMD_READ  = 2'b10,
    MMC_CMD_STOP  = 2'b11
  } mmc_cmd_t;

endpackage

/* File: testbench/mmc_measure_ctrl_props.sv */
// Checker: measurement sequencing and the link command handshake.
// Bound to the top module and sees only its ports.
`timescale 1ns/1ps
module mmc_measure_ctrl_props #(
  parameter int unsigned P_MEAS_CYC = 40
) (
  // Core domain
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic o_afe_power,
  input wire logic o_afe_selftest,
  input wire logic o_osc_run,
  // Link domain
  input wire logic i_lk_clk,
  input wire logic i_lk_cmd_valid,
  input wire logic o_lk_cmd_ready,
  input wire logic o_lk_rvalid
);
  logic [31:0] pw_cnt_ff;
  // Length of the running measurement, zero between them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pw_cnt_ff <= 32'h0;
    end else begin
      pw_cnt_ff <= o_afe_power ? pw_cnt_ff + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////
  property p_meas_len; @(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_afe_power) |-> pw_cnt_ff == P_MEAS_CYC; endproperty
  a_meas_len: assert property (p_meas_len) else $error("wrong measurement length");
  property p_meas_bound; @(posedge i_clk) disable iff (!i_rst_n)
    o_afe_power |-> pw_cnt_ff < P_MEAS_CYC; endproperty
  a_meas_bound: assert property (p_meas_bound) else $error("measurement overruns");
  property p_min_gap; @(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_afe_power) |-> !o_afe_power [*8]; endproperty
  a_min_gap: assert property (p_min_gap) else $error("front end powered too soon");
  property p_self_in_meas; @(posedge i_clk) disable iff (!i_rst_n)
    o_afe_selftest |-> o_afe_power; endproperty
  a_self_in_meas: assert property (p_self_in_meas) else $error("source on outside measurement");
  property p_osc_in_meas; @(posedge i_clk) disable iff (!i_rst_n)
    o_afe_power |-> o_osc_run; endproperty
  a_osc_in_meas: assert property (p_osc_in_meas) else $error("oscillator off while measuring");
  property p_ready_drop; @(posedge i_lk_clk) disable iff (!i_rst_n)
    i_lk_cmd_valid && o_lk_cmd_ready |=> !o_lk_cmd_ready; endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready stays after command");
  property p_answer; @(posedge i_lk_clk) disable iff (!i_rst_n)
    $fell(o_lk_cmd_ready) |-> ##[1:40] o_lk_cmd_ready; endproperty
  a_answer: assert property (p_answer) else $error("command never completes");
  property p_rvalid_pulse; @(posedge i_lk_clk) disable iff (!i_rst_n)
    o_lk_rvalid |=> !o_lk_rvalid; endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer too long");
endmodule

bind mmc_measure_ctrl mmc_measure_ctrl_props #(.P_MEAS_CYC(P_MEAS_CYC)) mmc_measure_ctrl_props_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .o_afe_power(o_afe_power), .o_afe_selftest(o_afe_selftest),
  .o_osc_run(o_osc_run), .i_lk_clk(i_lk_clk), .i_lk_cmd_valid(i_lk_cmd_valid),
  .o_lk_cmd_ready(o_lk_cmd_ready), .o_lk_rvalid(o_lk_rvalid));

/* File: testbench/mmc_host_model.sv */
// Host model: the bus engine side of the link command port.
// Assumes a free-running link clock; drives on its falling edge.
`timescale 1ns/1ps
module mmc_host_model import mmc_pkg::*; (
  // Link answers
  input  wire logic       i_lk_clk,
  input  wire logic       i_ready,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  // Link requests
  output logic            o_valid,
  output logic [1:0]      o_cmd,
  output logic [7:0]      o_data,
  // Set once a command or its answer never came
  output logic            o_stuck
);
  initial begin
    o_stuck = 1'b0;
    o_valid = 1'b0;
    o_cmd   = MMC_CMD_STOP;
    o_data  = 8'h00;
  end
  // Offer one command until taken; a read also waits for its answer
  task automatic cmd(input logic [1:0] c, input logic [7:0] d, output logic [7:0] rd);
    int n;
    rd = 8'h00;
    n = 0;
    @(negedge i_lk_clk);
    o_valid <= 1'b1;
    o_cmd   <= c;
    o_data  <= d;
    while (i_ready !== 1'b1 && n < 100) begin
      @(negedge i_lk_clk);
      n++;
    end
    if (i_ready !== 1'b1) begin
      o_stuck = 1'b1;
    end
    @(negedge i_lk_clk);
    o_valid <= 1'b0;
    o_data  <= ~d; // Released data must not keep its value
    while (c == MMC_CMD_READ && i_rvalid !== 1'b1 && n < 200) begin
      @(negedge i_lk_clk);
      n++;
    end
    if (c == MMC_CMD_READ && i_rvalid !== 1'b1) begin
      o_stuck = 1'b1;
    end
    rd = i_rdata;
  endtask
  // One write frame: pointer, byte, stop
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    cmd(MMC_CMD_PTR, a, x);
    cmd(MMC_CMD_WRITE, d, x);
    cmd(MMC_CMD_STOP, 8'h00, x);
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    cmd(MMC_CMD_PTR, a, x);
    cmd(MMC_CMD_READ, 8'h00, d);
    cmd(MMC_CMD_STOP, 8'h00, x);
  endtask
  // Only defined codes, always through power-down and a 100 us pause
  task automatic set_mode(input logic [4:0] m);
    put(ADDR_MODE, 8'h00);
    #100000;
    put(ADDR_MODE, {3'b000, m});
  endtask
endmodule

/* File: testbench/mmc_measure_ctrl_bench.sv */
// Testbench of the measure control, host model on the link side.
// Assumes shortened measurement and period counts set below.
`timescale 1ns/1ps
module mmc_measure_ctrl_bench import mmc_pkg::*;;
  localparam int unsigned MEAS     = 40;
  localparam int unsigned PER [4]  = '{400, 500, 600, 700};
  localparam logic [4:0]  CMODE [4] = '{MMC_MODE_CONT1, MMC_MODE_CONT2, MMC_MODE_CONT3, MMC_MODE_CONT4};
  localparam logic [7:0]  MAKER    = 8'h6b; // Arbitrary value
  localparam logic [7:0]  PART     = 8'h2d; // Arbitrary value
  logic               clk, rst_n, lk_clk, valid, hs, ready, rvalid, pw, st, osc, stuck;
  logic [1:0]         cmd;
  logic [7:0]         wdata, rdata;
  logic signed [15:0] ax, ay, az;
  int                 failures, n_compared, cyc;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Link clock, phase unrelated to the core clock
  initial begin
    lk_clk = 1'b0;
    #37;
    forever #62.5 lk_clk = ~lk_clk;
  end
  mmc_measure_ctrl #(.P_MEAS_CYC(MEAS), .P_PER1_CYC(PER[0]), .P_PER2_CYC(PER[1]), .P_PER3_CYC(PER[2]),
    .P_PER4_CYC(PER[3]), .P_MAKER_ID(MAKER), .P_PART_ID(PART)) mmc_measure_ctrl_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_lk_clk(lk_clk), .i_lk_cmd_valid(valid), .i_lk_cmd(cmd),
    .i_lk_data(wdata), .i_lk_hs(hs), .o_lk_cmd_ready(ready), .o_lk_rdata(rdata), .o_lk_rvalid(rvalid),
    .i_afe_x(ax), .i_afe_y(ay), .i_afe_z(az), .o_afe_power(pw), .o_afe_selftest(st), .o_osc_run(osc));
  mmc_host_model mmc_host_model_i (.i_lk_clk(lk_clk), .i_ready(ready), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_valid(valid), .o_cmd(cmd), .o_data(wdata), .o_stuck(stuck));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    mmc_host_model_i.get(a, d);
    chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, e});
  endtask
  // Waits on core falling edges, counting them, until the front end power is v
  task automatic wait_pw(input logic v);
    int n;
    n = 0;
    while (pw !== v && n < 5000) begin
      @(negedge clk);
      n++;
      cyc++;
    end
    chk("power level", {15'h0, pw}, {15'h0, v});
  endtask
  task automatic afe(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z);
    @(negedge clk);
    ax = x;
    ay = y;
    az = z;
  endtask
  // Reads X..Z in one frame; with gap set, a measurement ends before the frame closes
  task automatic burst(input logic [47:0] e, input logic gap);
    logic [7:0] d;
    mmc_host_model_i.cmd(MMC_CMD_PTR, ADDR_XL, d);
    for (int i = 0; i < 6; i++) begin
      mmc_host_model_i.cmd(MMC_CMD_READ, 8'h00, d);
      chk("result byte", {8'h00, d}, {8'h00, e[8*i +: 8]});
    end
    if (gap) begin
      wait_pw(1'b1);
      wait_pw(1'b0);
    end
    mmc_host_model_i.cmd(MMC_CMD_STOP, 8'h00, d);
  endtask
  ////////////////////////////////////////
  task automatic t_ident();
    rchk(ADDR_MODE, 8'h00);
    mmc_host_model_i.put(ADDR_MAKER, 8'hff);
    rchk(ADDR_MAKER, MAKER);
    rchk(ADDR_PART, PART);
    rchk(ADDR_MISC1, 8'h00);
    rchk(ADDR_MISC2, 8'h00);
    $display("test ident done");
  endtask
  task automatic t_single();
    afe(16'sd100, -16'sd200, 16'sd300);
    mmc_host_model_i.set_mode(MMC_MODE_SINGLE);
    wait_pw(1'b1);
    wait_pw(1'b0);
    rchk(ADDR_STA, 8'h01);
    rchk(ADDR_MODE, 8'h00);
    burst({16'sd300, -16'sd200, 16'sd100}, 1'b0);
    rchk(ADDR_STA, 8'h00);
    rchk(ADDR_STB, 8'h00);
    $display("test single done");
  endtask
  // Out-of-range field: clamped results and overflow
  task automatic t_self();
    afe(16'sd9000, -16'sd9000, 16'sd0);
    mmc_host_model_i.set_mode(MMC_MODE_SELF);
    wait_pw(1'b1);
    chk("source on", {15'h0, st}, 16'h0001);
    wait_pw(1'b0);
    burst({16'sh0000, 16'she002, 16'sh1ffe}, 1'b0);
    rchk(ADDR_STB, 8'h08);
    rchk(ADDR_STB, 8'h00);
    rchk(ADDR_MODE, 8'h00);
    // Second run with in-range values that pass through unclamped
    afe(16'sd10, -16'sd10, -16'sd200);
    mmc_host_model_i.set_mode(MMC_MODE_SELF);
    wait_pw(1'b1);
    wait_pw(1'b0);
    burst({-16'sd200, -16'sd10, 16'sd10}, 1'b0);
    $display("test selftest done");
  endtask
  task automatic t_cont();
    afe(16'sd0, 16'sd0, 16'sd0);
    for (int k = 0; k < 4; k++) begin
      mmc_host_model_i.set_mode(CMODE[k]);
      wait_pw(1'b1);
      wait_pw(1'b0);
      cyc = 0;
      chk("osc in gap", {15'h0, osc}, 16'h0001);
      wait_pw(1'b1);
      wait_pw(1'b0);
      chk("period", cyc[15:0], PER[k][15:0]);
      rchk(ADDR_STA, 8'h03);
      rchk(ADDR_ZH, 8'h00);
      rchk(ADDR_STA, 8'h00);
      mmc_host_model_i.set_mode(MMC_MODE_OFF);
      chk("osc off", {15'h0, osc}, 16'h0000);
    end
    $display("test continuous done");
  endtask
  task automatic t_skip();
    afe(16'sd5, 16'sd6, 16'sd7);
    mmc_host_model_i.set_mode(MMC_MODE_CONT1);
    wait_pw(1'b1);
    wait_pw(1'b0);
    afe(16'sd50, 16'sd60, 16'sd70);
    burst({16'sd7, 16'sd6, 16'sd5}, 1'b1);
    rchk(ADDR_STA, 8'h02);
    burst({16'sd7, 16'sd6, 16'sd5}, 1'b0);
    wait_pw(1'b1);
    wait_pw(1'b0);
    burst({16'sd70, 16'sd60, 16'sd50}, 1'b0);
    mmc_host_model_i.set_mode(MMC_MODE_OFF);
    $display("test skip done");
  endtask
  task automatic t_hs_soft_reset_bit();
    @(negedge clk);
    hs = 1'b1;
    rchk(ADDR_STA, 8'h80);
    @(negedge clk);
    hs = 1'b0;
    rchk(ADDR_STA, 8'h00);
    mmc_host_model_i.set_mode(MMC_MODE_CONT4);
    wait_pw(1'b1);
    wait_pw(1'b0);
    mmc_host_model_i.put(ADDR_SOFT_RESET_BIT, 8'h01);
    rchk(ADDR_SOFT_RESET_BIT, 8'h00);
    rchk(ADDR_MODE, 8'h00);
    rchk(ADDR_STA, 8'h00);
    chk("osc after reset", {15'h0, osc}, 16'h0000);
    $display("test speed and soft reset done");
  endtask
  ////////////////////////////////////////
  task automatic complete_run();
    chk("host stall", {15'h0, stuck}, 16'h0000);
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog: ample beyond the expected run of about 20000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    failures = 0;
    n_compared = 0;
    cyc = 0;
    rst_n = 1'b0;
    hs = 1'b0;
    ax = 16'sh0;
    ay = 16'sh0;
    az = 16'sh0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_ident();
    t_single();
    t_self();
    t_cont();
    t_skip();
    t_hs_soft_reset_bit();
    complete_run();
  end
endmodule
